// File: readout_pkg.sv
// Constants, types and register map of the pressure and temperature readout block.
// How it works
// - Pressure result is 24 bits in three bytes, high byte at lowest address.
// - Temperature result is 16 bits in two bytes, high byte at lower address.
// - Idle field counts 62.5 ms steps between periodic conversions, used only then.
// - Writing start flag one with select code 010 or 011 begins conversion; hardware clears it at end, except periodic.
// - Select code 010 runs temperature then pressure once.
// - Select code 011 repeats that pair, separated by the idle interval.
// - Pressure MSB one means negative; signed value is raw minus 2^24.
// - Temperature is two's complement, LSB 1/256 degree Celsius.
// - Format bit one gives unsigned output, but only with raw output selected.
// - Raw bit zero places calibrated data in results, one places raw data.
// - Diagnostics bit one runs the diagnosis function; this is the reset value.
// - Gain code n sets channel gain to two to the power n.
// - Oversampling code maps to ratios 1024X..8192X, 256X, 512X, 16384X, 32768X.
// - Swap bit exchanges positive and negative sensor inputs.
// - Device answers on the two-wire bus at address 0x6D.
// - Device acknowledges its address by pulling data low in the ninth clock.
package readout_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam real CLK_PERIOD_NS = 4.0;
   localparam real SLEEP_STEP_MS = 62.5;
   localparam int SLEEP_STEP_CYC = int'(SLEEP_STEP_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam real CONV_TIME_MS = 4.0;
   localparam int CONV_CYC = int'(CONV_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
   // -----------------------------------------------------------------
   // Bus address and register offsets
   // -----------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR = 7'h6d;
   localparam logic [7:0] PRES_H = 8'h06;
   localparam logic [7:0] PRES_M = 8'h07;
   localparam logic [7:0] PRES_L = 8'h08;
   localparam logic [7:0] TEMP_H = 8'h09;
   localparam logic [7:0] TEMP_L = 8'h0a;
   localparam logic [7:0] CMD_ADDR = 8'h30;
   localparam logic [7:0] SYS_ADDR = 8'ha5;
   localparam logic [7:0] PCFG_ADDR = 8'ha6;
   // -----------------------------------------------------------------
   // Reset values and fields
   // -----------------------------------------------------------------
   localparam logic [7:0] CMD_RST = 8'h00;
   localparam logic [7:0] SYS_RST = 8'h01;
   localparam logic [7:0] PCFG_RST = 8'h00;
   localparam int CMD_SCO = 3;
   localparam int SYS_DIAG = 0;
   localparam int SYS_RAW = 1;
   localparam int SYS_UNI = 2;
   localparam int PCFG_SWAP = 7;
   localparam logic [2:0] CTRL_COMBINED = 3'h2;
   localparam logic [2:0] CTRL_SLEEP = 3'h3;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   // -----------------------------------------------------------------
   // State encodings
   // -----------------------------------------------------------------
   typedef enum logic [7:0] {
      I_IDLE = 8'h01, I_ADDR = 8'h02, I_AACK = 8'h04, I_REG = 8'h08,
      I_SACK = 8'h10, I_WDATA = 8'h20, I_RDATA = 8'h40, I_RACK = 8'h80
   } bus_state_e;
   typedef enum logic [4:0] {
      C_IDLE = 5'h01, C_TEMP = 5'h02, C_PRES = 5'h04, C_DONE = 5'h08,
      C_SLEEP = 5'h10
   } conv_state_e;
endpackage

// File: pressure_temp_readout_regs.sv
// Two-wire register slave with conversion sequencer and result registers.
`timescale 1ns/1ps
module pressure_temp_readout_regs #(
   parameter int unsigned STEP_CYCLES = readout_pkg::SLEEP_STEP_CYC,
   parameter int unsigned CONV_CYCLES = readout_pkg::CONV_CYC
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Two-wire bus pins.
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Converter data.
   input wire logic [23:0] cal_pressure_i,
   input wire logic [15:0] cal_temperature_i,
   input wire logic [23:0] raw_pressure_i,
   input wire logic [15:0] raw_temperature_i,
   // Front-end control.
   output logic conv_temp_o,
   output logic conv_pres_o,
   output logic [7:0] gain_o,
   output logic [15:0] osr_o,
   output logic swap_inputs_o,
   output logic diag_enable_o
);
   import readout_pkg::*;

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic scl_m;
      logic scl_s;
      logic scl_d;
      logic sda_m;
      logic sda_s;
      logic sda_d;
      bus_state_e st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic rw;
      logic [7:0] ptr;
      logic oe;
      logic [7:0] cmd;
      logic [7:0] sys;
      logic [7:0] pcfg;
      logic [23:0] pres;
      logic [15:0] temp;
      conv_state_e cs;
      logic [31:0] timer;
      logic cvt_t;
      logic cvt_p;
      logic [7:0] gain;
      logic [15:0] osr;
   } state_s;

   state_s cur;
   state_s next;
   logic rise;
   logic fall;
   logic start;
   logic stop;

   // -----------------------------------------------------------------
   // Functions
   // -----------------------------------------------------------------
   // Register read decode; unmapped offsets read as zero.
   function automatic logic [7:0] reg_read(input logic [7:0] a, input state_s s);
      logic [7:0] r;
      r = 8'h00;
      unique case (a)
         PRES_H: r = s.pres[23:16];
         PRES_M: r = s.pres[15:8];
         PRES_L: r = s.pres[7:0];
         TEMP_H: r = s.temp[15:8];
         TEMP_L: r = s.temp[7:0];
         CMD_ADDR: r = s.cmd;
         SYS_ADDR: r = s.sys;
         PCFG_ADDR: r = s.pcfg;
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // Output format; temperature uses the top 16 bits.
   function automatic logic [23:0] fmt(input logic [23:0] cal, input logic [23:0] raw,
                                       input logic [7:0] sys);
      logic [23:0] f;
      f = cal;
      if (sys[SYS_RAW]) begin
         f = {raw[23] ^ sys[SYS_UNI], raw[22:0]};
      end
      return f;
   endfunction

   // Oversampling ratio from its code.
   function automatic logic [15:0] osr_ratio(input logic [2:0] c);
      logic [15:0] r;
      r = 16'h0400;
      unique case (c)
         3'h0: r = 16'h0400;
         3'h1: r = 16'h0800;
         3'h2: r = 16'h1000;
         3'h3: r = 16'h2000;
         3'h4: r = 16'h0100;
         3'h5: r = 16'h0200;
         3'h6: r = 16'h4000;
         3'h7: r = 16'h8000;
      endcase
      return r;
   endfunction

   // -----------------------------------------------------------------
   // Bus conditions from synchronised pins
   // -----------------------------------------------------------------
   // Only the second and delayed stages are looked at.
   assign rise = cur.scl_s & ~cur.scl_d;
   assign fall = ~cur.scl_s & cur.scl_d;
   assign start = cur.scl_s & cur.scl_d & cur.sda_d & ~cur.sda_s;
   assign stop = cur.scl_s & cur.scl_d & ~cur.sda_d & cur.sda_s;

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   // Sequencer first, then bus, so a bus write overrides a hardware clear.
   always_comb begin
      logic wr;
      logic [7:0] rd;
      logic [23:0] f;
      wr = 1'b0;
      rd = reg_read(cur.ptr, cur);
      f = 24'h000000;
      next = cur;
      next.scl_m = scl_i;
      next.scl_s = cur.scl_m;
      next.scl_d = cur.scl_s;
      next.sda_m = sda_i;
      next.sda_s = cur.sda_m;
      next.sda_d = cur.sda_s;

      // Conversion sequencer.
      unique case (cur.cs)
         C_IDLE: begin
            if (cur.cmd[CMD_SCO]) begin
               if (cur.cmd[2:0] == CTRL_COMBINED || cur.cmd[2:0] == CTRL_SLEEP) begin
                  next.cs = C_TEMP;
                  next.timer = 32'(CONV_CYCLES - 1);
               end else begin
                  next.cmd[CMD_SCO] = 1'b0;
               end
            end
         end
         C_TEMP: begin
            if (!cur.cmd[CMD_SCO]) begin
               next.cs = C_IDLE;
            end else if (cur.timer == 32'd0) begin
               f = fmt({cal_temperature_i, 8'h00}, {raw_temperature_i, 8'h00}, cur.sys);
               next.temp = f[23:8];
               next.cs = C_PRES;
               next.timer = 32'(CONV_CYCLES - 1);
            end else begin
               next.timer = cur.timer - 32'd1;
            end
         end
         C_PRES: begin
            if (!cur.cmd[CMD_SCO]) begin
               next.cs = C_IDLE;
            end else if (cur.timer == 32'd0) begin
               next.pres = fmt(cal_pressure_i, raw_pressure_i, cur.sys);
               next.cs = C_DONE;
            end else begin
               next.timer = cur.timer - 32'd1;
            end
         end
         C_DONE: begin
            if (cur.cmd[CMD_SCO] && cur.cmd[2:0] == CTRL_SLEEP) begin
               if (cur.cmd[7:4] == 4'h0) begin
                  next.cs = C_TEMP;
                  next.timer = 32'(CONV_CYCLES - 1);
               end else begin
                  next.cs = C_SLEEP;
                  next.timer = 32'(cur.cmd[7:4]) * 32'(STEP_CYCLES) - 32'd1;
               end
            end else begin
               next.cmd[CMD_SCO] = 1'b0;
               next.cs = C_IDLE;
            end
         end
         C_SLEEP: begin
            if (!cur.cmd[CMD_SCO]) begin
               next.cs = C_IDLE;
            end else if (cur.timer == 32'd0) begin
               next.cs = C_TEMP;
               next.timer = 32'(CONV_CYCLES - 1);
            end else begin
               next.timer = cur.timer - 32'd1;
            end
         end
         default: next.cs = C_IDLE;
      endcase

      // Two-wire slave.
      if (start) begin
         next.st = I_ADDR;
         next.bitcnt = 4'h0;
         next.oe = 1'b0;
      end else if (stop) begin
         next.st = I_IDLE;
         next.oe = 1'b0;
      end else begin
         unique case (cur.st)
            I_IDLE: next.oe = 1'b0;
            I_ADDR, I_REG, I_WDATA: begin
               if (rise && cur.bitcnt != BITS_PER_BYTE) begin
                  next.shreg = {cur.shreg[6:0], cur.sda_s};
                  next.bitcnt = cur.bitcnt + 4'h1;
               end else if (fall && cur.bitcnt == BITS_PER_BYTE) begin
                  if (cur.st == I_ADDR) begin
                     if (cur.shreg[7:1] == DEV_ADDR) begin
                        next.st = I_AACK;
                        next.oe = 1'b1;
                        next.rw = cur.shreg[0];
                     end else begin
                        next.st = I_IDLE;
                     end
                  end else begin
                     if (cur.st == I_REG) begin
                        next.ptr = cur.shreg;
                     end else begin
                        wr = 1'b1;
                        next.ptr = cur.ptr + 8'h01;
                     end
                     next.st = I_SACK;
                     next.oe = 1'b1;
                  end
               end
            end
            I_SACK: begin
               if (fall) begin
                  next.st = I_WDATA;
                  next.oe = 1'b0;
                  next.bitcnt = 4'h0;
               end
            end
            I_AACK, I_RACK: begin
               if (cur.st == I_RACK && rise && cur.sda_s) begin
                  next.st = I_IDLE;
               end else if (fall && cur.rw) begin
                  next.shreg = rd;
                  next.oe = ~rd[7];
                  next.ptr = cur.ptr + 8'h01;
                  next.bitcnt = 4'h0;
                  next.st = I_RDATA;
               end else if (fall) begin
                  next.st = I_REG;
                  next.oe = 1'b0;
                  next.bitcnt = 4'h0;
               end
            end
            I_RDATA: begin
               if (fall) begin
                  if (cur.bitcnt == LAST_BIT) begin
                     next.st = I_RACK;
                     next.oe = 1'b0;
                  end else begin
                     next.shreg = {cur.shreg[6:0], 1'b0};
                     next.oe = ~cur.shreg[6];
                     next.bitcnt = cur.bitcnt + 4'h1;
                  end
               end
            end
            default: next.st = I_IDLE;
         endcase
      end

      // Register writes; result registers are read only.
      if (wr) begin
         unique case (cur.ptr)
            CMD_ADDR: next.cmd = cur.shreg;
            SYS_ADDR: next.sys = cur.shreg;
            PCFG_ADDR: next.pcfg = cur.shreg;
            default: next.sys = next.sys;
         endcase
      end

      // Front-end control outputs.
      next.cvt_t = (next.cs == C_TEMP);
      next.cvt_p = (next.cs == C_PRES);
      next.gain = 8'h01 << cur.pcfg[5:3];
      next.osr = osr_ratio(cur.pcfg[2:0]);
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   // Synchronous active-low reset to constants; pins idle high.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         cur <= '0;
         cur.scl_m <= 1'b1;
         cur.scl_s <= 1'b1;
         cur.scl_d <= 1'b1;
         cur.sda_m <= 1'b1;
         cur.sda_s <= 1'b1;
         cur.sda_d <= 1'b1;
         cur.st <= I_IDLE;
         cur.cs <= C_IDLE;
         cur.cmd <= CMD_RST;
         cur.sys <= SYS_RST;
         cur.pcfg <= PCFG_RST;
         cur.gain <= 8'h01;
         cur.osr <= 16'h0400;
      end else begin
         cur <= next;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // Open-drain data: only ever drives low.
   assign sda_o = cur.sda_d & 1'b0;
   assign sda_oe_o = cur.oe;
   assign conv_temp_o = cur.cvt_t;
   assign conv_pres_o = cur.cvt_p;
   assign gain_o = cur.gain;
   assign osr_o = cur.osr;
   assign swap_inputs_o = cur.pcfg[PCFG_SWAP];
   assign diag_enable_o = cur.sys[SYS_DIAG];

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   // Helper for the assertions: a command write on this cycle.
   logic wr_cmd;
   assign wr_cmd = (cur.st == I_WDATA) && fall && (cur.bitcnt == BITS_PER_BYTE) &&
                   (cur.ptr == CMD_ADDR);

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   property p_pres_read;
      (fall && !start && !stop && cur.rw && cur.ptr == PRES_H &&
       (cur.st == I_AACK || (cur.st == I_RACK && !rise))) |=> cur.shreg == $past(cur.pres[23:16]);
   endproperty
   a_pres_read: assert property (p_pres_read) else $error("pressure high byte wrong");

   property p_temp_read;
      (fall && !start && !stop && cur.rw && cur.ptr == TEMP_H &&
       (cur.st == I_AACK || cur.st == I_RACK))
         |=> cur.shreg == $past(cur.temp[15:8]);
   endproperty
   a_temp_read: assert property (p_temp_read) else $error("temperature high byte wrong");

   property p_start;
      (cur.cs == C_IDLE && cur.cmd[CMD_SCO] && cur.cmd[2:0] == CTRL_COMBINED)
         |=> cur.cs == C_TEMP ##1 conv_temp_o;
   endproperty
   a_start: assert property (p_start) else $error("conversion did not start");

   property p_pair;
      (cur.cs == C_TEMP && cur.cmd[CMD_SCO] && cur.timer == 32'd0) |=> cur.cs == C_PRES;
   endproperty
   a_pair: assert property (p_pair) else $error("pressure did not follow");

   property p_repeat;
      (cur.cs == C_DONE && cur.cmd[CMD_SCO] && cur.cmd[2:0] == CTRL_SLEEP && !wr_cmd)
         |=> cur.cmd[CMD_SCO] && (cur.cs == C_SLEEP || cur.cs == C_TEMP);
   endproperty
   a_repeat: assert property (p_repeat) else $error("periodic mode stopped");

   property p_done;
      (cur.cs == C_PRES && cur.cmd[CMD_SCO] && cur.timer == 32'd0 && cur.cmd[2:0] == CTRL_COMBINED)
         ##1 !wr_cmd |=> !cur.cmd[CMD_SCO] && $stable(cur.pres);
   endproperty
   a_done: assert property (p_done) else $error("flag cleared before results");

   property p_unsigned;
      (cur.cs == C_PRES && cur.cmd[CMD_SCO] && cur.timer == 32'd0 && cur.sys[SYS_RAW] &&
       cur.sys[SYS_UNI]) |=> cur.pres[23] != $past(raw_pressure_i[23]);
   endproperty
   a_unsigned: assert property (p_unsigned) else $error("unsigned format wrong");

   property p_gain;
      $changed(cur.pcfg) |=> ##1 gain_o == (8'h01 << cur.pcfg[5:3]);
   endproperty
   a_gain: assert property (p_gain) else $error("gain does not follow code");

   property p_addr_nack;
      (cur.st == I_ADDR && fall && cur.bitcnt == BITS_PER_BYTE && cur.shreg[7:1] != DEV_ADDR)
         |=> cur.st == I_IDLE && !sda_oe_o;
   endproperty
   a_addr_nack: assert property (p_addr_nack) else $error("foreign address acknowledged");

   property p_ack;
      (cur.st == I_ADDR && fall && !start && !stop && cur.bitcnt == BITS_PER_BYTE &&
       cur.shreg[7:1] == DEV_ADDR) |=> sda_oe_o throughout (cur.st == I_AACK)[*1];
   endproperty
   a_ack: assert property (p_ack) else $error("address not acknowledged");
endmodule // pressure_temp_readout_regs

// File: bus_master_model.sv
// Two-wire bus master model that reaches the registers of the readout block.
`timescale 1ns/1ps
module bus_master_model (
   // Bus lines.
   output logic scl_o,
   output logic sda_o,
   input wire logic sda_i
);
   import readout_pkg::*;
   localparam real QTR_NS = 31.25;
   logic nack_seen;
   // Bus idles high, as the pull-ups leave it.
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      nack_seen = 1'b0;
   end
   // One bit slot of 125 ns; data moves only while the clock is low.
   task automatic bit_slot(input logic b, output logic s);
      sda_o = b;
      #(QTR_NS);
      scl_o = 1'b1;
      #(QTR_NS);
      s = sda_i;
      #(QTR_NS);
      scl_o = 1'b0;
      #(QTR_NS);
   endtask
   // Start or repeated start: data falls while the clock is high.
   task automatic start();
      sda_o = 1'b1;
      #(QTR_NS);
      scl_o = 1'b1;
      #(QTR_NS);
      sda_o = 1'b0;
      #(QTR_NS);
      scl_o = 1'b0;
      nack_seen = 1'b0;
      #(QTR_NS);
   endtask
   // Stop: data rises while the clock is high.
   task automatic stop();
      sda_o = 1'b0;
      #(QTR_NS);
      scl_o = 1'b1;
      #(QTR_NS);
      sda_o = 1'b1;
      #(QTR_NS);
   endtask
   // Sends a byte MSB first and records a missing acknowledge.
   task automatic put_byte(input logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) bit_slot(v[i], s);
      bit_slot(1'b1, s);
      if (s) nack_seen = 1'b1;
   endtask
   // Receives a byte; the last one is refused to end the read.
   task automatic get_byte(input logic last, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) bit_slot(1'b1, v[i]);
      bit_slot(last, s);
   endtask
   // Writes one register through the device address.
   task automatic wr_reg(input logic [7:0] r, input logic [7:0] d);
      start();
      put_byte({DEV_ADDR, 1'b0});
      put_byte(r);
      put_byte(d);
      stop();
   endtask
   // Reads n registers from r in one burst, first byte most significant.
   task automatic rd_regs(input logic [7:0] r, input int n, output logic [39:0] v);
      logic [7:0] b;
      v = 40'h0;
      start();
      put_byte({DEV_ADDR, 1'b0});
      put_byte(r);
      start();
      put_byte({DEV_ADDR, 1'b1});
      for (int k = 0; k < n; k++) begin
         get_byte(k == n - 1, b);
         v = {v[31:0], b};
      end
      stop();
   endtask
endmodule // bus_master_model

// File: pressure_temp_readout_regs_tb.sv
// Self-checking testbench of the readout register block.
`timescale 1ns/1ps
module pressure_temp_readout_regs_tb;
   import readout_pkg::*;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   logic clk_i, rst_b_i, scl, m_sda, sda_o, sda_oe_o, sda_line;
   logic [23:0] cal_p, raw_p;
   logic [15:0] cal_t, raw_t;
   logic conv_temp_o, conv_pres_o, swap_inputs_o, diag_enable_o;
   logic [7:0] gain_o;
   logic [15:0] osr_o;
   int err_count, comparisons, cycles;
   localparam logic [15:0] OSR_TAB [8] = '{16'h0400, 16'h0800, 16'h1000, 16'h2000,
      16'h0100, 16'h0200, 16'h4000, 16'h8000};
   // Open-drain data line with pull-up.
   assign sda_line = m_sda & (sda_oe_o ? sda_o : 1'b1);
   bus_master_model i_bus_master_model (.scl_o(scl), .sda_o(m_sda), .sda_i(sda_line));
   pressure_temp_readout_regs #(.STEP_CYCLES(50), .CONV_CYCLES(20))
      i_pressure_temp_readout_regs (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .cal_pressure_i(cal_p),
      .cal_temperature_i(cal_t), .raw_pressure_i(raw_p), .raw_temperature_i(raw_t),
      .conv_temp_o(conv_temp_o), .conv_pres_o(conv_pres_o), .gain_o(gain_o),
      .osr_o(osr_o), .swap_inputs_o(swap_inputs_o), .diag_enable_o(diag_enable_o));
   // Clock of 4 ns period.
   always #2 clk_i = ~clk_i;
   // ---------------------------------------------------------------
   // Checking and closing
   // ---------------------------------------------------------------
   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Cuts a hang short.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         err_count++;
         final_report();
      end
   end
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Reset values, an unmapped read, a write to a read-only place, a foreign address.
   task automatic t_reset();
      logic [39:0] v;
      i_bus_master_model.rd_regs(PRES_H, 5, v);
      check(v, 40'h0);
      i_bus_master_model.rd_regs(CMD_ADDR, 1, v);
      check(v, 40'(CMD_RST));
      i_bus_master_model.rd_regs(SYS_ADDR, 2, v);
      check(v, 40'({SYS_RST, PCFG_RST}));
      i_bus_master_model.wr_reg(PRES_M, 8'h5a);
      i_bus_master_model.rd_regs(PRES_M, 1, v);
      check(v, 40'h0);
      i_bus_master_model.rd_regs(8'h50, 1, v);
      check(v, 40'h0);
      check({gain_o, osr_o, swap_inputs_o, diag_enable_o}, 40'({8'h01, 16'h0400, 2'h1}));
      i_bus_master_model.start();
      i_bus_master_model.put_byte(8'hd8);
      i_bus_master_model.stop();
      check(i_bus_master_model.nack_seen, 40'h1);
   endtask
   // Every gain and oversampling code, with the swap bit toggling.
   task automatic t_channel();
      logic [2:0] c;
      logic [39:0] v;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         i_bus_master_model.wr_reg(PCFG_ADDR, {c[0], 1'b0, c, c});
         check(i_bus_master_model.nack_seen, 40'h0);
         check(40'(gain_o), 40'(8'h01 << c));
         check(40'(osr_o), 40'(OSR_TAB[i]));
         check(40'(swap_inputs_o), 40'(c[0]));
      end
      i_bus_master_model.rd_regs(PCFG_ADDR, 1, v);
      check(v, 40'hbf);
   endtask
   // Single combined conversion: poll the start flag, then read all results at once.
   task automatic t_conv(input logic [7:0] sys, input logic [7:0] cmd, input logic [39:0] exp);
      logic [39:0] v;
      i_bus_master_model.wr_reg(SYS_ADDR, sys);
      check(40'(diag_enable_o), 40'(sys[0]));
      i_bus_master_model.wr_reg(CMD_ADDR, cmd);
      v = 40'h8;
      for (int k = 0; k < 8 && v[3] !== 1'b0; k++) begin
         i_bus_master_model.rd_regs(CMD_ADDR, 1, v);
      end
      check(v, 40'(cmd & 8'hf7));
      i_bus_master_model.rd_regs(PRES_H, 5, v);
      check(v, exp);
      check(40'($signed(v[39:16]) / 8), 40'($signed(exp[39:16]) / 8));
   endtask
   // Periodic conversion: spacing of pairs and a flag that stays set until aborted.
   task automatic t_sleep();
      int gap;
      logic [39:0] v;
      i_bus_master_model.wr_reg(CMD_ADDR, 8'h2b);
      gap = 0;
      while (conv_pres_o !== 1'b1 && gap < 3000) begin
         @(negedge clk_i);
         gap++;
      end
      while (conv_pres_o !== 1'b0 && gap < 3000) begin
         @(negedge clk_i);
         gap++;
      end
      gap = 0;
      while (conv_temp_o !== 1'b1 && gap < 3000) begin
         @(negedge clk_i);
         gap++;
      end
      check(40'(gap >= 98 && gap <= 102), 40'h1);
      i_bus_master_model.rd_regs(CMD_ADDR, 1, v);
      check(v, 40'h2b);
      i_bus_master_model.wr_reg(CMD_ADDR, 8'h00);
      repeat (200) @(posedge clk_i);
      check({conv_temp_o, conv_pres_o}, 40'h0);
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      rst_b_i = 1'b0;
      err_count = 0;
      comparisons = 0;
      cycles = 0;
      cal_p = 24'h0;
      cal_t = 16'h0;
      raw_p = 24'h0;
      raw_t = 16'h0;
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      cal_p <= 24'h801234;
      cal_t <= 16'hfe80;
      raw_p <= 24'h123456;
      raw_t <= 16'h8765;
      repeat (3) @(posedge clk_i);
      t_reset();
      t_channel();
      t_conv(8'h01, 8'h0a, 40'h801234_fe80);
      t_conv(8'h02, 8'hfa, 40'h123456_8765);
      t_conv(8'h07, 8'h0a, 40'h923456_0765);
      t_conv(8'h05, 8'h0a, 40'h801234_fe80);
      t_sleep();
      final_report();
   end
endmodule // pressure_temp_readout_regs_tb
